/* common/sbad_params.svh */
// Constants for the system bus arbiter and address decoder.
// Assumes a 32-bit byte address and four fixed master slots.
`ifndef SBAD_PARAMS_SVH
`define SBAD_PARAMS_SVH

`define SBAD_MASTERS 4
`define SBAD_PRIO_W 3
`define SBAD_RGN_INTERNAL 4'h0
`define SBAD_RGN_EXT_FIRST 4'h1
`define SBAD_RGN_EXT_LAST 4'h8
`define SBAD_RGN_PERIPH 4'hF
`define SBAD_AREA_BOOT 8'h00
`define SBAD_AREA_ROM 8'h01
`define SBAD_AREA_SRAM 8'h02
`define SBAD_AREA_USB 8'h03
`define SBAD_EXT0_BASE 32'h1000_0000
`define SBAD_AREA_MASK 32'h000F_FFFF
`define SBAD_ROM_MASK 32'h0001_FFFF
`define SBAD_SRAM_MASK 32'h0000_3FFF
`define SBAD_BOOT_ROM 1'b1
`define SBAD_RST_REMAP 1'b0

`endif

/* common/sbad_pkg.sv */
// Types shared by the bus arbiter and decoder and its surroundings.
// Assumes sbad_params.svh supplies the numeric constants.
package sbad_pkg;

  typedef enum logic [1:0] {SBAD_BYTE, SBAD_HALF, SBAD_WORD} sbad_size_type;
  typedef enum logic [1:0] {SBAD_READ, SBAD_WRITE, SBAD_FETCH} sbad_kind_type;
  typedef enum logic [1:0] {SBAD_IDLE, SBAD_ACTIVE, SBAD_ABORT} sbad_phase_type;

  typedef struct packed {
    logic req;
    logic [31:0] addr;
    sbad_size_type size;
    sbad_kind_type kind;
  } sbad_req_type;

  typedef struct packed {
    logic rom;
    logic sram;
    logic usb;
    logic periph;
    logic [7:0] ext;
  } sbad_sel_type;

  typedef struct packed {
    logic [31:0] addr;
    sbad_size_type size;
    sbad_kind_type kind;
    logic undef;
    logic misal;
    logic [3:0] mst;
    logic [3:0] seen;
  } sbad_stat_type;

  typedef struct packed {
    sbad_phase_type phase;
    logic [3:0] grant;
    logic [31:0] addr;
    sbad_size_type size;
    sbad_kind_type kind;
    sbad_sel_type sel;
    logic abort;
    sbad_stat_type stat;
    logic remap;
    logic boot_rom;
    logic pin_meta;
    logic pin_sync;
  } sbad_state_type;

endpackage : sbad_pkg

/* hw/sbad_bus_controller.sv */
// System bus controller: priority arbiter for four masters, address decoder,
// boot and remap mapping, misalignment check and abort capture.
// Assumes slaves pulse i_xfer_done when a selected transfer ends.
`timescale 1ns/1ns
`include "sbad_params.svh"

module sbad_bus_controller
  import sbad_pkg::*;
(
  // Clock and reset.
  input logic i_clk,
  input logic i_sys_rst,
  // Master requests, slot 0 first, and their priorities.
  input sbad_req_type [3:0] i_req,
  input logic [3:0][2:0] i_prio,
  // Slave side.
  input logic i_xfer_done,
  output logic [3:0] o_grant,
  output sbad_sel_type o_sel,
  output logic [31:0] o_slave_addr,
  output sbad_size_type o_size,
  output sbad_kind_type o_kind,
  output logic o_abort,
  // Control and status bits.
  input logic i_boot_select_pin,
  input logic i_remap_toggle_bit,
  input logic i_abort_status_read,
  output logic o_remapped,
  output logic o_boot_rom,
  output sbad_stat_type o_abort_status
);

  sbad_state_type st_reg;
  sbad_state_type st_next;
  sbad_req_type rq;
  sbad_sel_type dsel;
  logic [31:0] daddr;
  logic [1:0] win;
  logic [2:0] best;
  logic found;
  logic dundef;
  logic dmis;
  logic take;

  always_comb begin
    st_next = st_reg;
    win = 2'd0;
    best = 3'd0;
    found = 1'b0;
    dsel = '0;
    dundef = 1'b0;
    st_next.abort = 1'b0;
    st_next.pin_meta = i_boot_select_pin;
    st_next.pin_sync = st_reg.pin_meta;
    // Strict compare keeps the lower slot on a tie.
    for (int m = 0; m < `SBAD_MASTERS; m++) begin
      if (i_req[m].req && (!found || i_prio[m] > best)) begin
        found = 1'b1;
        best = i_prio[m];
        win = 2'(m);
      end
    end
    rq = i_req[win];
    daddr = rq.addr;
    if (rq.addr[31:28] == `SBAD_RGN_INTERNAL) begin
      if (rq.addr[27:20] == `SBAD_AREA_BOOT) begin
        if (st_reg.remap) begin
          dsel.sram = 1'b1;
        end else if (st_reg.boot_rom == `SBAD_BOOT_ROM) begin
          dsel.rom = 1'b1;
        end else begin
          dsel.ext[0] = 1'b1;
        end
      end else if (rq.addr[27:20] == `SBAD_AREA_ROM) begin
        dsel.rom = 1'b1;
      end else if (rq.addr[27:20] == `SBAD_AREA_SRAM) begin
        dsel.sram = 1'b1;
      end else if (rq.addr[27:20] == `SBAD_AREA_USB) begin
        dsel.usb = 1'b1;
      end else begin
        dundef = 1'b1;
      end
      if (dsel.rom) begin
        daddr = rq.addr & `SBAD_ROM_MASK;
      end else if (dsel.sram) begin
        daddr = rq.addr & `SBAD_SRAM_MASK;
      end else if (dsel.ext[0]) begin
        daddr = `SBAD_EXT0_BASE | (rq.addr & `SBAD_AREA_MASK);
      end else begin
        daddr = rq.addr & `SBAD_AREA_MASK;
      end
    end else if (rq.addr[31:28] >= `SBAD_RGN_EXT_FIRST && rq.addr[31:28] <= `SBAD_RGN_EXT_LAST) begin
      dsel.ext[3'(rq.addr[31:28] - `SBAD_RGN_EXT_FIRST)] = 1'b1;
    end else if (rq.addr[31:28] == `SBAD_RGN_PERIPH) begin
      dsel.periph = 1'b1;
    end else begin
      dundef = 1'b1;
    end
    // Only processor fetches skip the check; byte lanes are little-endian.
    dmis = !(rq.kind == SBAD_FETCH && win == 2'd0) &&
           ((rq.size == SBAD_WORD && rq.addr[1:0] != 2'b00) ||
            (rq.size == SBAD_HALF && rq.addr[0]));
    take = (st_reg.phase == SBAD_IDLE) && found;
    if (i_remap_toggle_bit) begin
      st_next.remap = !st_reg.remap;
    end
    if (i_abort_status_read) begin
      st_next.stat.seen = 4'h0;
    end
    case (st_reg.phase)
      SBAD_IDLE: begin
        if (found) begin
          st_next.grant = 4'h1 << win;
          st_next.addr = daddr;
          st_next.size = rq.size;
          st_next.kind = rq.kind;
          if (dundef || dmis) begin
            st_next.phase = SBAD_ABORT;
            st_next.sel = '0;
            st_next.abort = 1'b1;
            // A new abort sets the seen bit of the previous source even on a read,
            // and the current source stays out of seen because mst already shows it.
            st_next.stat.seen = (st_next.stat.seen | st_reg.stat.mst) & ~(4'h1 << win);
            st_next.stat.mst = 4'h1 << win;
            st_next.stat.addr = rq.addr;
            st_next.stat.size = rq.size;
            st_next.stat.kind = rq.kind;
            st_next.stat.undef = dundef;
            st_next.stat.misal = dmis;
          end else begin
            st_next.phase = SBAD_ACTIVE;
            st_next.sel = dsel;
          end
        end
      end
      SBAD_ACTIVE: begin
        if (i_xfer_done) begin
          st_next.phase = SBAD_IDLE;
          st_next.grant = 4'h0;
          st_next.sel = '0;
        end
      end
      SBAD_ABORT: begin
        st_next.phase = SBAD_IDLE;
        st_next.grant = 4'h0;
      end
      default: begin
        st_next.phase = SBAD_IDLE;
      end
    endcase
    if (i_sys_rst) begin
      st_next = '0;
      st_next.phase = SBAD_IDLE;
      st_next.remap = `SBAD_RST_REMAP;
      st_next.pin_meta = i_boot_select_pin;
      st_next.pin_sync = st_reg.pin_meta;
      // The synchronised pin level tracks the last cycles of reset.
      st_next.boot_rom = st_reg.pin_sync;
    end
  end

  always_ff @(posedge i_clk) begin
    st_reg <= st_next;
  end

  assign o_grant = st_reg.grant;
  assign o_sel = st_reg.sel;
  assign o_slave_addr = st_reg.addr;
  assign o_size = st_reg.size;
  assign o_kind = st_reg.kind;
  assign o_abort = st_reg.abort;
  assign o_remapped = st_reg.remap;
  assign o_boot_rom = st_reg.boot_rom;
  assign o_abort_status = st_reg.stat;

  property p_high_first;
    @(posedge i_clk) disable iff (i_sys_rst)
    st_reg.phase == SBAD_IDLE && i_req[3].req && i_req[0].req && i_prio[3] > i_prio[0]
    |=> !st_reg.grant[0];
  endproperty
  a_high_first: assert property (p_high_first) else $error("lower priority won");

  property p_tie_order;
    @(posedge i_clk) disable iff (i_sys_rst)
    st_reg.phase == SBAD_IDLE && i_req[0].req && i_req[1].req && i_prio[0] >= i_prio[1]
    |=> !st_reg.grant[1];
  endproperty
  a_tie_order: assert property (p_tie_order) else $error("tie order broken");

  property p_hold;
    @(posedge i_clk) disable iff (i_sys_rst)
    st_reg.phase == SBAD_ACTIVE && !i_xfer_done |=> $stable(st_reg.grant) && o_grant != 4'h0;
  endproperty
  a_hold: assert property (p_hold) else $error("grant moved mid transfer");

  property p_undef_rgn;
    @(posedge i_clk) disable iff (i_sys_rst)
    take && rq.addr[31:28] inside {[4'h9:4'hE]} |=> o_abort && o_sel == '0 ##1 !o_abort;
  endproperty
  a_undef_rgn: assert property (p_undef_rgn) else $error("undefined region no abort");

  property p_int_hole;
    @(posedge i_clk) disable iff (i_sys_rst)
    take && rq.addr[31:28] == 4'h0 && rq.addr[27:20] > 8'h03 |=> o_abort_status.undef && o_abort;
  endproperty
  a_int_hole: assert property (p_int_hole) else $error("internal hole no abort");

  property p_boot_area;
    @(posedge i_clk) disable iff (i_sys_rst)
    take && rq.addr[31:20] == 12'h000 && !st_reg.remap && st_reg.boot_rom && !dmis |=> o_sel.rom;
  endproperty
  a_boot_area: assert property (p_boot_area) else $error("area 0 not boot rom");

  property p_remap_area;
    @(posedge i_clk) disable iff (i_sys_rst)
    take && rq.addr[31:20] == 12'h000 && st_reg.remap && !dmis |=> o_sel.sram && !o_sel.rom;
  endproperty
  a_remap_area: assert property (p_remap_area) else $error("remap not to sram");

  property p_misal;
    @(posedge i_clk) disable iff (i_sys_rst)
    take && rq.kind == SBAD_WRITE && rq.size == SBAD_WORD && rq.addr[1:0] != 2'b00
    |=> o_abort && o_abort_status.misal;
  endproperty
  a_misal: assert property (p_misal) else $error("misaligned word not aborted");

  property p_abort_src;
    @(posedge i_clk) disable iff (i_sys_rst)
    o_abort |-> o_abort_status.mst == o_grant && o_abort_status.addr[1:0] == $past(rq.addr[1:0]);
  endproperty
  a_abort_src: assert property (p_abort_src) else $error("abort source wrong");

  property p_toggle;
    @(posedge i_clk) disable iff (i_sys_rst)
    i_remap_toggle_bit |=> o_remapped != $past(o_remapped);
  endproperty
  a_toggle: assert property (p_toggle) else $error("remap did not toggle");

  property p_ext_cs;
    @(posedge i_clk) disable iff (i_sys_rst)
    take && rq.addr[31:28] == 4'h1 && !dmis |=> o_sel.ext == 8'h01;
  endproperty
  a_ext_cs: assert property (p_ext_cs) else $error("chip select zero missed");

  property p_alias;
    @(posedge i_clk) disable iff (i_sys_rst)
    o_sel.rom |-> o_slave_addr[31:17] == 15'h0000;
  endproperty
  a_alias: assert property (p_alias) else $error("rom address not aliased");

  // A processor fetch inside the mapped internal areas never aborts on alignment.
  property p_fetch_exempt;
    @(posedge i_clk) disable iff (i_sys_rst)
    take && win == 2'd0 && rq.kind == SBAD_FETCH && rq.addr[31:22] == 10'h000 |=> !o_abort;
  endproperty
  a_fetch_exempt: assert property (p_fetch_exempt) else $error("fetch was aborted");

  // The captured boot choice only moves while reset is applied.
  property p_boot_latch;
    @(posedge i_clk) disable iff (i_sys_rst)
    1'b1 |=> $stable(o_boot_rom);
  endproperty
  a_boot_latch: assert property (p_boot_latch) else $error("boot choice moved");

  property p_cov_abort;
    @(posedge i_clk) disable iff (i_sys_rst)
    o_abort ##1 take;
  endproperty
  c_cov_abort: cover property (p_cov_abort);

  property p_cov_contend;
    @(posedge i_clk) disable iff (i_sys_rst)
    take && i_req[2].req && i_req[3].req;
  endproperty
  c_cov_contend: cover property (p_cov_contend);

  property p_cov_remap;
    @(posedge i_clk) disable iff (i_sys_rst)
    o_remapped && o_sel.sram;
  endproperty
  c_cov_remap: cover property (p_cov_remap);

  property p_cov_tie;
    @(posedge i_clk) disable iff (i_sys_rst)
    take && i_req[0].req && i_req[1].req && i_prio[0] == i_prio[1];
  endproperty
  c_cov_tie: cover property (p_cov_tie);

endmodule : sbad_bus_controller

/* bench/sbad_slave_model.sv */
// Slave side model: answers any raised select with a done pulse i_wait+1 cycles later.
// Assumes selects hold until the edge that samples done high.
`timescale 1ns/1ns

module sbad_slave_model
  import sbad_pkg::*;
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Select and response.
  input wire sbad_sel_type i_sel,
  input wire logic [3:0] i_wait,
  output logic o_done
);
  logic [3:0] cnt_reg;

  // Single little-endian beats only; the pulse drops once sampled.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || i_sel == '0 || o_done) begin
      cnt_reg <= 4'h0;
      o_done <= 1'b0;
    end else if (cnt_reg >= i_wait) begin
      o_done <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end
endmodule : sbad_slave_model

/* bench/testbench.sv */
// Self-checking bench for the bus arbiter and address decoder.
// Assumes the slave model ends every selected transfer.
`timescale 1ns/1ns

module testbench;
  import sbad_pkg::*;
  logic i_clk, i_sys_rst, i_xfer_done, i_boot_select_pin, i_remap_toggle_bit;
  logic i_abort_status_read, o_abort, o_remapped, o_boot_rom;
  sbad_req_type [3:0] i_req;
  logic [3:0][2:0] i_prio;
  logic [3:0] o_grant, slow;
  sbad_sel_type o_sel;
  logic [31:0] o_slave_addr;
  sbad_size_type o_size;
  sbad_kind_type o_kind;
  sbad_stat_type o_abort_status;
  int fail_count, n_checks;

  sbad_bus_controller dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_req(i_req),
    .i_prio(i_prio), .i_xfer_done(i_xfer_done), .o_grant(o_grant), .o_sel(o_sel),
    .o_slave_addr(o_slave_addr), .o_size(o_size), .o_kind(o_kind), .o_abort(o_abort),
    .i_boot_select_pin(i_boot_select_pin), .i_remap_toggle_bit(i_remap_toggle_bit),
    .i_abort_status_read(i_abort_status_read), .o_remapped(o_remapped),
    .o_boot_rom(o_boot_rom), .o_abort_status(o_abort_status));
  sbad_slave_model slave (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_sel(o_sel),
    .i_wait(slow), .o_done(i_xfer_done));

  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask : chk

  task automatic start(input int m, input logic [31:0] a, input sbad_size_type sz,
                       input sbad_kind_type kd);
    i_req[m] <= '{1'b1, a, sz, kd};
  endtask : start

  // Waits for the answer to master m, checks it and releases the request.
  task automatic wait_end(input int m, input logic ab, input logic [11:0] es,
                          input logic [31:0] ea);
    int n;
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (o_abort !== 1'b1 && o_sel === 12'h0 && n < 40);
    chk(o_grant === 4'(1 << m), "grant");
    chk(o_abort === ab, "abort");
    if (ab) begin
      chk(o_sel === 12'h0, "select on abort");
      chk(o_abort_status.mst === 4'(1 << m), "abort master");
      chk(o_abort_status.addr === i_req[m].addr, "abort address");
    end else begin
      chk(o_sel === es, "select");
      chk(o_slave_addr === ea, "slave address");
      chk(o_size === i_req[m].size && o_kind === i_req[m].kind, "size and kind");
      n = 0;
      while (i_xfer_done !== 1'b1 && n < 40) begin
        @(negedge i_clk);
        n++;
      end
      chk(i_xfer_done === 1'b1, "transfer end");
    end
    @(posedge i_clk);
    i_req[m].req <= 1'b0;
  endtask : wait_end

  task automatic xfer(input int m, input logic [31:0] a, input sbad_size_type sz,
                      input sbad_kind_type kd, input logic ab, input logic [11:0] es,
                      input logic [31:0] ea);
    @(posedge i_clk);
    start(m, a, sz, kd);
    wait_end(m, ab, es, ea);
  endtask : xfer

  task automatic pulse_remap;
    @(posedge i_clk);
    i_remap_toggle_bit <= 1'b1;
    @(posedge i_clk);
    i_remap_toggle_bit <= 1'b0;
  endtask : pulse_remap

  task automatic reboot(input logic pin);
    @(posedge i_clk);
    i_sys_rst <= 1'b1;
    i_boot_select_pin <= pin;
    repeat (20) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(negedge i_clk);
    chk(o_boot_rom === pin, "boot select");
    chk(o_remapped === 1'b0 && o_grant === 4'h0, "reset state");
    chk(o_abort_status === '0, "status reset");
  endtask : reboot

  task automatic decode_map;
    xfer(0, 32'h0020_0004, SBAD_WORD, SBAD_READ, 0, 12'h400, 32'h4);
    xfer(1, 32'h0012_0000, SBAD_WORD, SBAD_READ, 0, 12'h800, 32'h0);
    xfer(2, 32'h0031_2344, SBAD_WORD, SBAD_WRITE, 0, 12'h200, 32'h1_2344);
    xfer(0, 32'h0000_0010, SBAD_WORD, SBAD_READ, 0, 12'h800, 32'h10);
    xfer(3, 32'h1000_0008, SBAD_BYTE, SBAD_READ, 0, 12'h001, 32'h1000_0008);
    xfer(3, 32'h8000_0000, SBAD_WORD, SBAD_READ, 0, 12'h080, 32'h8000_0000);
    xfer(1, 32'hF000_0100, SBAD_WORD, SBAD_WRITE, 0, 12'h100, 32'hF000_0100);
    xfer(1, 32'h9000_0000, SBAD_WORD, SBAD_READ, 1, 12'h0, 32'h0);
    chk(o_abort_status.undef === 1'b1, "undefined flag");
    xfer(0, 32'hE000_0000, SBAD_WORD, SBAD_READ, 1, 12'h0, 32'h0);
    xfer(2, 32'h0040_0000, SBAD_WORD, SBAD_READ, 1, 12'h0, 32'h0);
  endtask : decode_map

  task automatic align_and_status;
    xfer(0, 32'h0020_0002, SBAD_HALF, SBAD_READ, 0, 12'h400, 32'h2);
    xfer(0, 32'h0020_0003, SBAD_BYTE, SBAD_WRITE, 0, 12'h400, 32'h3);
    xfer(0, 32'h0020_0002, SBAD_WORD, SBAD_FETCH, 0, 12'h400, 32'h2);
    xfer(1, 32'h0020_0001, SBAD_HALF, SBAD_FETCH, 1, 12'h0, 32'h0);
    xfer(3, 32'h0020_0002, SBAD_WORD, SBAD_WRITE, 1, 12'h0, 32'h0);
    chk(o_abort_status.misal === 1'b1 && o_abort_status.kind === SBAD_WRITE, "kind");
    chk(o_abort_status.size === SBAD_WORD && o_abort_status.seen[1] === 1'b1, "seen");
    @(posedge i_clk);
    i_abort_status_read <= 1'b1;
    @(posedge i_clk);
    i_abort_status_read <= 1'b0;
    @(negedge i_clk);
    chk(o_abort_status.seen === 4'h0, "seen clear");
  endtask : align_and_status

  task automatic remap_steps;
    pulse_remap();
    @(negedge i_clk);
    chk(o_remapped === 1'b1, "remap on");
    xfer(0, 32'h0000_0020, SBAD_WORD, SBAD_READ, 0, 12'h400, 32'h20);
    pulse_remap();
    @(negedge i_clk);
    chk(o_remapped === 1'b0, "remap off");
    xfer(0, 32'h0000_0004, SBAD_WORD, SBAD_READ, 0, 12'h800, 32'h4);
  endtask : remap_steps

  task automatic arbitrate;
    slow <= 4'h5;
    i_prio <= {3'h2, 3'h5, 3'h5, 3'h1};
    @(posedge i_clk);
    start(3, 32'h0020_0000, SBAD_WORD, SBAD_READ);
    start(2, 32'h0020_0004, SBAD_WORD, SBAD_READ);
    start(1, 32'h0020_0008, SBAD_WORD, SBAD_READ);
    wait_end(1, 0, 12'h400, 32'h8);
    wait_end(2, 0, 12'h400, 32'h4);
    wait_end(3, 0, 12'h400, 32'h0);
    i_prio <= {3'h7, 3'h0, 3'h0, 3'h0};
    @(posedge i_clk);
    start(0, 32'h0020_0010, SBAD_WORD, SBAD_READ);
    start(3, 32'h0020_0014, SBAD_WORD, SBAD_READ);
    start(1, 32'h0020_0018, SBAD_WORD, SBAD_READ);
    wait_end(3, 0, 12'h400, 32'h14);
    wait_end(0, 0, 12'h400, 32'h10);
    wait_end(1, 0, 12'h400, 32'h18);
    slow <= 4'h0;
  endtask : arbitrate

  initial begin
    #200000;
    fail_count++;
    conclude();
  end

  initial begin
    fail_count = 0;
    n_checks = 0;
    i_sys_rst = 1'b1;
    i_req = '0;
    i_prio = {3'h3, 3'h2, 3'h1, 3'h0};
    slow = 4'h0;
    i_boot_select_pin = 1'b1;
    i_remap_toggle_bit = 1'b0;
    i_abort_status_read = 1'b0;
    reboot(1'b1);
    decode_map();
    align_and_status();
    remap_steps();
    arbitrate();
    reboot(1'b0);
    xfer(0, 32'h0000_0004, SBAD_WORD, SBAD_READ, 0, 12'h001, 32'h1000_0004);
    conclude();
  end
endmodule : testbench
